// ==== rtcs_pkg.sv ====
// Constants, field layout and types shared by the clock core and its divider.
// Assumes one 250 MHz system clock and a separate 32.768 kHz oscillator clock.
package rtcs_pkg;

  // ****************************************
  // Widths and types
  // ****************************************
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned NUM_TIME = 8;
  localparam int unsigned NUM_MEM = 24;
  localparam int unsigned ACC_W = 16;
  typedef logic [ADDR_W-1:0] rtcs_addr_t;
  typedef logic [7:0] rtcs_byte_t;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam rtcs_addr_t ADDR_SUBSEC = 5'h00;
  localparam rtcs_addr_t ADDR_SECONDS = 5'h01;
  localparam rtcs_addr_t ADDR_HOURS = 5'h03;
  localparam rtcs_addr_t ADDR_WEEKDAY = 5'h04;
  localparam rtcs_addr_t ADDR_YEAR = 5'h07;
  localparam rtcs_addr_t ADDR_MEM_BASE = 5'h08;
  localparam rtcs_addr_t ADDR_WDOG = 5'h09;
  localparam rtcs_addr_t ADDR_HT = 5'h0c;
  localparam rtcs_addr_t ADDR_FLAGS = 5'h0f;
  localparam rtcs_addr_t MEM_IDX_WDOG = 5'h01;
  localparam rtcs_addr_t MEM_IDX_HT = 5'h04;
  localparam rtcs_addr_t MEM_IDX_FLAGS = 5'h07;

  // Time byte indices
  localparam int unsigned IDX_SUBSEC = 0;
  localparam int unsigned IDX_SEC = 1;
  localparam int unsigned IDX_MIN = 2;
  localparam int unsigned IDX_HOUR = 3;
  localparam int unsigned IDX_WDAY = 4;
  localparam int unsigned IDX_MDAY = 5;
  localparam int unsigned IDX_MONTH = 6;
  localparam int unsigned IDX_YEAR = 7;

  // ****************************************
  // Bit positions and masks
  // ****************************************
  localparam int unsigned OSC_HALT_BIT = 7;
  localparam int unsigned CENTURY_LOW_BIT = 6;
  localparam int unsigned CENTURY_HIGH_BIT = 7;
  localparam int unsigned OSC_FAIL_BIT = 2;
  localparam int unsigned OSC_FAIL_IRQ_EN_BIT = 7;
  localparam int unsigned HALT_UPDATE_BIT = 6;
  localparam rtcs_byte_t FLAGS_RD_MASK = 8'hf8;

  // ****************************************
  // BCD limits
  // ****************************************
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam rtcs_byte_t BCD_00 = 8'h00;
  localparam rtcs_byte_t BCD_01 = 8'h01;
  localparam rtcs_byte_t BCD_07 = 8'h07;
  localparam rtcs_byte_t BCD_12 = 8'h12;
  localparam rtcs_byte_t BCD_23 = 8'h23;
  localparam rtcs_byte_t BCD_28 = 8'h28;
  localparam rtcs_byte_t BCD_29 = 8'h29;
  localparam rtcs_byte_t BCD_30 = 8'h30;
  localparam rtcs_byte_t BCD_31 = 8'h31;
  localparam rtcs_byte_t BCD_59 = 8'h59;
  localparam rtcs_byte_t BCD_99 = 8'h99;
  localparam rtcs_byte_t MONTH_FEB = 8'h02;
  localparam rtcs_byte_t MONTH_APR = 8'h04;
  localparam rtcs_byte_t MONTH_JUN = 8'h06;
  localparam rtcs_byte_t MONTH_SEP = 8'h09;
  localparam rtcs_byte_t MONTH_NOV = 8'h11;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned MCLK_HZ = 250_000_000;
  localparam int unsigned OSC_HZ = 32_768;
  localparam int unsigned TICK_HZ = 100;
  localparam int unsigned RST_HOLD_MS = 210;
  localparam int unsigned RST_HOLD_CYCLES = RST_HOLD_MS * (MCLK_HZ / 1000);
  localparam int unsigned OSC_FAIL_US = 100;
  localparam int unsigned OSC_FAIL_CYCLES = OSC_FAIL_US * (MCLK_HZ / 1_000_000);

endpackage

// ==== rtcs_osc_if.sv ====
// Carrier between the clock core and its oscillator-domain divider.
// Toggles carry events across; halt is a level; the receiver synchronises.
interface rtcs_osc_if;
  logic halt;
  logic clr_tgl;
  logic tick_tgl;
  logic beat_tgl;
  modport osc (input halt, input clr_tgl, output tick_tgl, output beat_tgl);
  modport core (output halt, output clr_tgl, input tick_tgl, input beat_tgl);
endinterface

// ==== rtcs_osc_div.sv ====
// Oscillator-domain divider: turns the 32.768 kHz clock into hundredths ticks.
// Assumes rst_n, halt and clr_tgl come from the system clock domain.
module rtcs_osc_div
  import rtcs_pkg::*;
#(
  parameter int unsigned DIV_IN_HZ = rtcs_pkg::OSC_HZ,
  parameter int unsigned DIV_OUT_HZ = rtcs_pkg::TICK_HZ,
  parameter int unsigned DIV_ACC_W = rtcs_pkg::ACC_W
)
(
  // Oscillator clock, reset from the system domain
  input wire logic osc_clk,
  input wire logic rst_n,
  // Link to the core
  rtcs_osc_if.osc osc
);

  if (DIV_OUT_HZ == 0 || DIV_OUT_HZ >= DIV_IN_HZ || DIV_IN_HZ >= (1 << DIV_ACC_W))
  begin : g_bad_div
    $error("rtcs_osc_div: divider parameters out of range");
  end

  // ****************************************
  // Synchronisers
  // ****************************************
  logic [2:0] sq0_q, sq1_q, sq2_q, flt_q;
  logic o_rst_n, o_halt, o_clr;

  always_ff @(posedge osc_clk)
  begin
    sq0_q <= {rst_n, osc.halt, osc.clr_tgl};
    sq1_q <= sq0_q;
    sq2_q <= sq1_q;
    // A change counts once the second and third stages agree
    flt_q <= (sq1_q & ~(sq1_q ^ sq2_q)) | (flt_q & (sq1_q ^ sq2_q));
  end

  assign o_rst_n = flt_q[2];
  assign o_halt = flt_q[1];
  assign o_clr = flt_q[0];

  // ****************************************
  // Fractional divider
  // ****************************************
  // Exact 100 ticks per 32768 cycles, no drift from an integer ratio
  logic [DIV_ACC_W-1:0] acc_q;
  logic [DIV_ACC_W:0] acc_sum;
  logic wrap;
  logic [DIV_ACC_W-1:0] acc_nxt;
  logic tick_q, beat_q, clr_seen_q;

  assign acc_sum = {1'b0, acc_q} + (DIV_ACC_W+1)'(DIV_OUT_HZ);
  assign wrap = acc_sum >= (DIV_ACC_W+1)'(DIV_IN_HZ);
  assign acc_nxt = wrap ? DIV_ACC_W'(acc_sum - (DIV_ACC_W+1)'(DIV_IN_HZ)) : acc_sum[DIV_ACC_W-1:0];

  always_ff @(posedge osc_clk)
  begin
    if (!o_rst_n)
    begin
      acc_q <= '0;
      tick_q <= 1'b0;
      beat_q <= 1'b0;
      clr_seen_q <= 1'b0;
    end
    else
    begin
      clr_seen_q <= o_clr;
      if (o_clr != clr_seen_q)
        acc_q <= '0;
      else if (!o_halt)
      begin
        acc_q <= acc_nxt;
        tick_q <= tick_q ^ wrap;
        beat_q <= ~beat_q;
      end
    end
  end

  assign osc.tick_tgl = tick_q;
  assign osc.beat_tgl = beat_q;

endmodule

// ==== rtcs_core.sv ====
// Clock core: BCD time counters, snapshot buffers, register file, supply-fail
// handling and reset pin. Assumes a byte-level host port from the bus slave.
module rtcs_core
  import rtcs_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = rtcs_pkg::RST_HOLD_CYCLES,
  parameter int unsigned FAIL_CYCLES = rtcs_pkg::OSC_FAIL_CYCLES
)
(
  // System clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Oscillator clock
  input wire logic osc_clk,
  // Supply comparator
  input wire logic supply_fail,
  // Host byte port
  input wire logic acc_start,
  input wire logic acc_stop,
  input wire logic ptr_load,
  input wire rtcs_pkg::rtcs_addr_t ptr_val,
  input wire logic wr_stb,
  input wire rtcs_pkg::rtcs_byte_t wr_data,
  input wire logic rd_stb,
  output rtcs_pkg::rtcs_byte_t rd_data,
  // Reset pin, open drain
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe_n,
  // Oscillator-fail interrupt
  output logic osc_fail_irq_n
);
  import rtcs_pkg::*;

  if (HOLD_CYCLES < 1 || FAIL_CYCLES < 2)
  begin : g_bad_par
    $error("rtcs_core: hold or fail count too small");
  end

  localparam int unsigned HOLD_W = $clog2(HOLD_CYCLES + 1);
  localparam int unsigned FAIL_W = $clog2(FAIL_CYCLES + 1);
  localparam logic [HOLD_W-1:0] HOLD_END = HOLD_W'(HOLD_CYCLES);
  localparam logic [FAIL_W-1:0] FAIL_END = FAIL_W'(FAIL_CYCLES);
  localparam logic [FAIL_W-1:0] FAIL_LAST = FAIL_W'(FAIL_CYCLES - 1);

  // ****************************************
  // Oscillator divider
  // ****************************************
  rtcs_osc_if osc_bus ();
  logic clr_tgl_q;

  rtcs_osc_div u_div (
    .osc_clk (osc_clk),
    .rst_n (rst_n),
    .osc (osc_bus.osc)
  );

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [2:0] sq0_q, sq1_q, sq2_q, flt_q;
  logic sf_prev_q, tick_prev_q, beat_prev_q;
  logic sf, sf_rise, tick_evt, beat_evt;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sq0_q <= 3'h0;
      sq1_q <= 3'h0;
      sq2_q <= 3'h0;
      flt_q <= 3'h0;
      sf_prev_q <= 1'b0;
      tick_prev_q <= 1'b0;
      beat_prev_q <= 1'b0;
    end
    else
    begin
      sq0_q <= {supply_fail, osc_bus.tick_tgl, osc_bus.beat_tgl};
      sq1_q <= sq0_q;
      sq2_q <= sq1_q;
      flt_q <= (sq1_q & ~(sq1_q ^ sq2_q)) | (flt_q & (sq1_q ^ sq2_q));
      sf_prev_q <= flt_q[2];
      tick_prev_q <= flt_q[1];
      beat_prev_q <= flt_q[0];
    end
  end

  assign sf = flt_q[2];
  assign sf_rise = sf & ~sf_prev_q;
  assign tick_evt = flt_q[1] ^ tick_prev_q;
  assign beat_evt = flt_q[0] ^ beat_prev_q;

  // ****************************************
  // Host access decode
  // ****************************************
  rtcs_byte_t cnt_q [NUM_TIME];
  rtcs_byte_t buf_q [NUM_TIME];
  rtcs_byte_t buf_in [NUM_TIME];
  rtcs_byte_t mem_q [NUM_MEM];
  rtcs_addr_t ptr_q, mem_idx;
  logic dirty_q, ht_q, of_q;
  logic start_ok, stop_ok, load_ok, wr_ok, rd_ok;
  logic is_time, wr_time, at_last, commit, snap;

  assign start_ok = acc_start & ~sf;
  assign stop_ok = acc_stop & ~sf;
  assign load_ok = ptr_load & ~sf;
  assign wr_ok = wr_stb & ~sf;
  assign rd_ok = rd_stb & ~sf;
  assign is_time = ptr_q <= ADDR_YEAR;
  assign wr_time = wr_ok & is_time;
  assign at_last = ptr_q == ADDR_YEAR;
  assign mem_idx = ptr_q - ADDR_MEM_BASE;
  // Write-back at stop, or when the pointer steps past the last time byte
  assign commit = (stop_ok & dirty_q) | ((wr_ok | rd_ok) & at_last & (dirty_q | wr_time));
  // Fail snapshot always; access snapshot only while not frozen
  assign snap = sf_rise | (start_ok & ~ht_q & ~commit);

  // ****************************************
  // BCD counter chain
  // ****************************************
  function automatic logic [8:0] bcd_step(input rtcs_byte_t v, input rtcs_byte_t lo,
                                          input rtcs_byte_t hi);
    logic [8:0] r;
    if (v >= hi)
      r = {1'b1, lo};
    else if (v[3:0] == BCD_DIGIT_MAX)
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    else
      r = {1'b0, v + 8'h01};
    return r;
  endfunction

  function automatic rtcs_byte_t month_len(input rtcs_byte_t mon, input rtcs_byte_t yr);
    logic leap;
    rtcs_byte_t r;
    // Every fourth year, from the BCD digits directly
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    if (mon == MONTH_FEB)
      r = leap ? BCD_29 : BCD_28;
    else if (mon == MONTH_APR || mon == MONTH_JUN || mon == MONTH_SEP || mon == MONTH_NOV)
      r = BCD_30;
    else
      r = BCD_31;
    return r;
  endfunction

  rtcs_byte_t adv [NUM_TIME];
  rtcs_byte_t step_v, mlen;
  logic carry, wk_carry;

  assign mlen = month_len({3'h0, cnt_q[IDX_MONTH][4:0]}, cnt_q[IDX_YEAR]);

  always_comb
  begin
    adv = cnt_q;
    step_v = BCD_00;
    wk_carry = 1'b0;
    {carry, adv[IDX_SUBSEC]} = bcd_step(cnt_q[IDX_SUBSEC], BCD_00, BCD_99);
    if (carry)
    begin
      {carry, step_v} = bcd_step({1'b0, cnt_q[IDX_SEC][6:0]}, BCD_00, BCD_59);
      adv[IDX_SEC] = {cnt_q[IDX_SEC][OSC_HALT_BIT], step_v[6:0]};
    end
    if (carry)
      {carry, adv[IDX_MIN]} = bcd_step({1'b0, cnt_q[IDX_MIN][6:0]}, BCD_00, BCD_59);
    if (carry)
    begin
      {carry, step_v} = bcd_step({2'h0, cnt_q[IDX_HOUR][5:0]}, BCD_00, BCD_23);
      adv[IDX_HOUR][5:0] = step_v[5:0];
    end
    if (carry)
    begin
      {wk_carry, step_v} = bcd_step({5'h00, cnt_q[IDX_WDAY][2:0]}, BCD_01, BCD_07);
      adv[IDX_WDAY] = {5'h00, step_v[2:0]};
      {carry, adv[IDX_MDAY]} = bcd_step({2'h0, cnt_q[IDX_MDAY][5:0]}, BCD_01, mlen);
    end
    if (carry)
      {carry, adv[IDX_MONTH]} = bcd_step({3'h0, cnt_q[IDX_MONTH][4:0]}, BCD_01, BCD_12);
    if (carry)
      {carry, adv[IDX_YEAR]} = bcd_step(cnt_q[IDX_YEAR], BCD_00, BCD_99);
    if (carry)
      adv[IDX_HOUR][CENTURY_HIGH_BIT:CENTURY_LOW_BIT] =
        cnt_q[IDX_HOUR][CENTURY_HIGH_BIT:CENTURY_LOW_BIT] + 2'h1;
  end

  // ****************************************
  // Counters and buffers
  // ****************************************
  always_comb
  begin
    for (int i = 0; i < NUM_TIME; i++)
      buf_in[i] = (wr_time && ptr_q[2:0] == 3'(i)) ? wr_data : buf_q[i];
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_TIME; i++)
        cnt_q[i] <= (i == IDX_WDAY || i == IDX_MDAY || i == IDX_MONTH) ? BCD_01 : BCD_00;
    end
    else if (commit)
      cnt_q <= buf_in;
    else if (tick_evt)
      cnt_q <= adv;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_TIME; i++)
        buf_q[i] <= BCD_00;
    end
    else if (snap)
      buf_q <= cnt_q;
    else
      buf_q <= buf_in;
  end

  // Any time write, even halt or century only, clears the divider
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      clr_tgl_q <= 1'b0;
    else if (commit)
      clr_tgl_q <= ~clr_tgl_q;
  end

  assign osc_bus.clr_tgl = clr_tgl_q;
  assign osc_bus.halt = cnt_q[IDX_SEC][OSC_HALT_BIT];

  // ****************************************
  // Pointer, write tracking, register file
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_n || sf_rise)
    begin
      ptr_q <= ADDR_SUBSEC;
      dirty_q <= 1'b0;
    end
    else
    begin
      if (load_ok)
        ptr_q <= ptr_val;
      else if (wr_ok || rd_ok)
        ptr_q <= ptr_q + 5'h01;
      if (commit)
        dirty_q <= 1'b0;
      else if (wr_time)
        dirty_q <= 1'b1;
    end
  end

  // User memory keeps its contents across supply fail; only writes stop
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_MEM; i++)
        mem_q[i] <= BCD_00;
    end
    else if (wr_ok && !is_time)
      mem_q[mem_idx] <= wr_data;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      ht_q <= 1'b0;
    else if (sf_rise)
      ht_q <= 1'b1;
    else if (wr_ok && ptr_q == ADDR_HT)
      ht_q <= wr_data[HALT_UPDATE_BIT];
  end

  // ****************************************
  // Oscillator-fail detect
  // ****************************************
  logic [FAIL_W-1:0] fail_cnt_q;
  logic fail_evt, of_clr, irq_n_q;

  // A halted oscillator is expected to stop, so it never counts as failed
  assign fail_evt = (fail_cnt_q == FAIL_LAST) & ~beat_evt & ~osc_bus.halt;
  assign of_clr = wr_ok & (ptr_q == ADDR_FLAGS) & ~wr_data[OSC_FAIL_BIT];

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      fail_cnt_q <= '0;
      of_q <= 1'b0;
      irq_n_q <= 1'b1;
    end
    else
    begin
      if (beat_evt || osc_bus.halt)
        fail_cnt_q <= '0;
      else if (fail_cnt_q != FAIL_END)
        fail_cnt_q <= fail_cnt_q + FAIL_W'(1);
      of_q <= fail_evt | (of_q & ~of_clr);
      irq_n_q <= ~(of_q & mem_q[MEM_IDX_WDOG][OSC_FAIL_IRQ_EN_BIT]);
    end
  end

  assign osc_fail_irq_n = irq_n_q;

  // ****************************************
  // Read data
  // ****************************************
  rtcs_byte_t rd_sel, rd_q;
  rtcs_byte_t ht_byte, flags_byte;

  assign ht_byte = {mem_q[MEM_IDX_HT][7], ht_q, mem_q[MEM_IDX_HT][5:0]};
  assign flags_byte = (mem_q[MEM_IDX_FLAGS] & FLAGS_RD_MASK) | {5'h00, of_q, 2'h0};
  assign rd_sel = is_time ? buf_q[ptr_q[2:0]] :
                  (ptr_q == ADDR_HT) ? ht_byte :
                  (ptr_q == ADDR_FLAGS) ? flags_byte : mem_q[mem_idx];

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      rd_q <= BCD_00;
    else
      rd_q <= rd_sel;
  end

  assign rd_data = rd_q;

  // ****************************************
  // Reset pin hold
  // ****************************************
  // Only the pin waits; registers are usable as soon as supply is back
  logic [HOLD_W-1:0] hold_q;
  logic oe_n_q;

  always_ff @(posedge mclk)
  begin
    if (!rst_n || sf)
    begin
      hold_q <= '0;
      oe_n_q <= 1'b0;
    end
    else if (hold_q != HOLD_END)
    begin
      hold_q <= hold_q + HOLD_W'(1);
      oe_n_q <= 1'b0;
    end
    else
      oe_n_q <= 1'b1;
  end

  assign rst_pin_o = 1'b0;
  assign rst_pin_oe_n = oe_n_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_sf_aborts: assert property ($rose(sf) |=> ptr_q == ADDR_SUBSEC && !dirty_q)
    else $error("supply fail did not clear pointer");
  a_sf_freezes: assert property ($rose(sf) |=> ht_q && buf_q[IDX_SEC] == $past(cnt_q[IDX_SEC]))
    else $error("supply fail did not stamp time");
  a_sf_blocks: assert property (sf && !sf_rise && (wr_stb || ptr_load)
      |=> $stable(ptr_q) && $stable(mem_q[MEM_IDX_WDOG]) && $stable(buf_q[IDX_SUBSEC]))
    else $error("write taken during supply fail");
  a_start_snap: assert property (start_ok && !ht_q && !commit
      |=> buf_q[IDX_SUBSEC] == $past(cnt_q[IDX_SUBSEC]) && buf_q[IDX_YEAR] == $past(cnt_q[IDX_YEAR]))
    else $error("no snapshot at access start");
  a_ht_frozen: assert property (start_ok && ht_q && !wr_stb |=> $stable(buf_q[IDX_SUBSEC]))
    else $error("snapshot taken while frozen");
  a_commit_load: assert property (commit
      |=> cnt_q[IDX_SUBSEC] == $past(buf_in[IDX_SUBSEC]) && cnt_q[IDX_YEAR] == $past(buf_in[IDX_YEAR]))
    else $error("counters not loaded from buffers");
  a_past_last: assert property (wr_ok && at_last |-> commit ##1 clr_tgl_q != $past(clr_tgl_q))
    else $error("no commit past last time byte");
  a_rst_fail: assert property (sf |=> !rst_pin_oe_n [*2])
    else $error("reset pin released during fail");
  a_rst_late: assert property ($rose(rst_pin_oe_n) |-> !sf && $past(hold_q) == HOLD_END)
    else $error("reset pin released early");
  a_hold_open: assert property (!sf && !rst_pin_oe_n && wr_ok && ptr_q == ADDR_WDOG
      |=> mem_q[MEM_IDX_WDOG] == $past(wr_data))
    else $error("write blocked by hold interval");
  a_of_set: assert property (fail_evt |=> of_q ##1 (of_q || $past(of_clr)))
    else $error("oscillator fail flag lost");
  a_irq_out: assert property (of_q && mem_q[MEM_IDX_WDOG][OSC_FAIL_IRQ_EN_BIT] |=> !osc_fail_irq_n)
    else $error("interrupt not raised");
  a_bcd_wrap: assert property (tick_evt && !commit && cnt_q[IDX_SUBSEC] == BCD_99
      |=> cnt_q[IDX_SUBSEC] == BCD_00)
    else $error("hundredths did not wrap");

  c_fail_cycle: cover property ($rose(sf) ##[1:200] $fell(sf));
  c_commit_stop: cover property (stop_ok && dirty_q);
  c_of_raised: cover property ($rose(of_q));
  c_frozen_read: cover property (start_ok && ht_q);

endmodule

// ==== rtcs_host_model.sv ====
// Host-side partner: drives the core's byte port as a bus master would.
// Assumes the bench's mclk; strobes rise and fall on falling edges only.
module rtcs_host_model
  import rtcs_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Byte port toward the core
  output logic acc_start,
  output logic acc_stop,
  output logic ptr_load,
  output rtcs_pkg::rtcs_addr_t ptr_val,
  output logic wr_stb,
  output rtcs_pkg::rtcs_byte_t wr_data,
  output logic rd_stb,
  input wire rtcs_pkg::rtcs_byte_t rd_data
);
  timeunit 1ns;
  timeprecision 100ps;
  import rtcs_pkg::*;

  initial
  begin
    {acc_start, acc_stop, ptr_load, wr_stb, rd_stb} = '0;
    ptr_val = '0;
    wr_data = '0;
  end

  // One strobe for one edge: 0 start, 1 pointer, 2 write, 3 read, 4 stop
  task automatic pulse(input int k, input rtcs_byte_t v);
    @(negedge mclk);
    acc_start = (k == 0);
    ptr_load = (k == 1);
    wr_stb = (k == 2);
    rd_stb = (k == 3);
    acc_stop = (k == 4);
    ptr_val = v[4:0];
    wr_data = v;
    @(negedge mclk);
    {acc_start, ptr_load, wr_stb, rd_stb, acc_stop} = '0;
    // Released data must not look valid
    ptr_val = ~ptr_val;
    wr_data = ~wr_data;
  endtask

  // Callers keep unchanged neighbour fields in shared bytes
  task automatic write_seq(input rtcs_addr_t a, input rtcs_byte_t d [8], input int n);
    pulse(0, 8'h00);
    pulse(1, {3'h0, a});
    for (int i = 0; i < n; i++)
    begin
      pulse(2, d[i]);
    end
    pulse(4, 8'h00);
  endtask

  // Never steps past the last byte read, so a read never commits
  task automatic read_seq(input rtcs_addr_t a, input bit lp, input int n,
                          output rtcs_byte_t d [8]);
    d = '{default: 8'h00};
    pulse(0, 8'h00);
    if (lp)
    begin
      pulse(1, {3'h0, a});
    end
    repeat (2) @(negedge mclk);
    for (int i = 0; i < n; i++)
    begin
      if (i > 0)
      begin
        pulse(3, 8'h00);
        @(negedge mclk);
      end
      d[i] = rd_data;
    end
    pulse(4, 8'h00);
  endtask
endmodule

// ==== rtcs_core_tb_top.sv ====
// Self-checking bench for the clock core with a host partner model.
// Assumes shortened hold and oscillator-fail counts set below.
module rtcs_core_tb_top
  import rtcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Setup
  // ****************************************
  localparam int HOLD = 20;
  localparam int FAILC = 400;
  localparam int TICKW = 12000;
  localparam rtcs_byte_t TV [8] = '{8'h50, 8'h30, 8'h45, 8'h63, 8'h03, 8'h15, 8'h11, 8'h24};
  localparam rtcs_byte_t RV [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
  logic mclk = 1'b0;
  logic osc_clk = 1'b0;
  logic osc_run = 1'b1;
  logic rst_n = 1'b0;
  logic supply_fail = 1'b0;
  logic acc_start, acc_stop, ptr_load, wr_stb, rd_stb;
  rtcs_addr_t ptr_val;
  rtcs_byte_t wr_data, rd_data;
  logic rst_pin_i, rst_pin_o, rst_pin_oe_n, osc_fail_irq_n;
  rtcs_byte_t got [8];
  rtcs_byte_t ev [8];
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  // Pull-up on the open-drain reset pin
  assign rst_pin_i = rst_pin_oe_n ? 1'b1 : rst_pin_o;

  initial forever #2 mclk = ~mclk;
  // Oscillator stands still while gated off
  initial
  begin
    #7;
    forever #32 osc_clk = osc_run ? ~osc_clk : osc_clk;
  end

  rtcs_core #(.HOLD_CYCLES(HOLD), .FAIL_CYCLES(FAILC)) i_dut (.mclk(mclk), .rst_n(rst_n),
    .osc_clk(osc_clk), .supply_fail(supply_fail), .acc_start(acc_start), .acc_stop(acc_stop),
    .ptr_load(ptr_load), .ptr_val(ptr_val), .wr_stb(wr_stb), .wr_data(wr_data),
    .rd_stb(rd_stb), .rd_data(rd_data), .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o),
    .rst_pin_oe_n(rst_pin_oe_n), .osc_fail_irq_n(osc_fail_irq_n));

  rtcs_host_model i_host (.mclk(mclk), .acc_start(acc_start), .acc_stop(acc_stop),
    .ptr_load(ptr_load), .ptr_val(ptr_val), .wr_stb(wr_stb), .wr_data(wr_data),
    .rd_stb(rd_stb), .rd_data(rd_data));

  // ****************************************
  // Checking
  // ****************************************
  task automatic check(input rtcs_byte_t seen, input rtcs_byte_t exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cmpn(input rtcs_byte_t g [8], input rtcs_byte_t e [8], input int n);
    for (int i = 0; i < n; i++)
    begin
      check(g[i], e[i]);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard well above the planned run
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    // Oscillator domain needs many edges to see the reset
    repeat (100) @(negedge mclk);
    rst_n = 1'b1;
    fork
      i_host.read_seq(ADDR_SUBSEC, 1'b1, 8, got);
      begin
        repeat (HOLD - 2) @(negedge mclk);
        check({7'h0, rst_pin_oe_n}, 8'h00);
      end
    join
    check({7'h0, rst_pin_oe_n}, 8'h01);
    cmpn(got, RV, 8);
    i_host.write_seq(ADDR_SECONDS, '{0: 8'h80, default: 8'h00}, 1);
    i_host.write_seq(ADDR_SECONDS, '{default: 8'h00}, 1);
    i_host.write_seq(ADDR_SUBSEC, TV, 8);
    i_host.read_seq(ADDR_SUBSEC, 1'b1, 8, got);
    cmpn(got, TV, 8);
    // Halt: partial write keeps the other snapshot bytes
    i_host.write_seq(ADDR_SECONDS, '{0: 8'hb0, default: 8'h00}, 1);
    repeat (TICKW) @(negedge mclk);
    ev = TV;
    ev[1] = 8'hb0;
    i_host.read_seq(ADDR_SUBSEC, 1'b1, 8, got);
    cmpn(got, ev, 8);
    i_host.write_seq(ADDR_SECONDS, '{0: 8'h30, default: 8'h00}, 1);
    repeat (TICKW) @(negedge mclk);
    i_host.read_seq(ADDR_SUBSEC, 1'b1, 1, got);
    check(got[0], 8'h52);
    // Oscillator failure
    i_host.write_seq(ADDR_WDOG, '{0: 8'h80, default: 8'h00}, 1);
    osc_run = 1'b0;
    repeat (FAILC + 100) @(negedge mclk);
    i_host.read_seq(ADDR_FLAGS, 1'b1, 1, got);
    check(got[0], 8'h04);
    check({7'h0, osc_fail_irq_n}, 8'h00);
    osc_run = 1'b1;
    i_host.write_seq(ADDR_FLAGS, '{default: 8'h00}, 1);
    i_host.read_seq(ADDR_FLAGS, 1'b1, 1, got);
    check(got[0], 8'h00);
    check({7'h0, osc_fail_irq_n}, 8'h01);
    // Supply failure with a write attempt in the middle
    i_host.write_seq(ADDR_SUBSEC, TV, 8);
    supply_fail = 1'b1;
    repeat (10) @(negedge mclk);
    check({7'h0, rst_pin_oe_n}, 8'h00);
    i_host.write_seq(5'h10, '{0: 8'haa, default: 8'h00}, 1);
    supply_fail = 1'b0;
    repeat (6) @(negedge mclk);
    check({7'h0, rst_pin_oe_n}, 8'h00);
    i_host.read_seq(ADDR_SUBSEC, 1'b0, 8, got);
    cmpn(got, TV, 8);
    i_host.read_seq(5'h10, 1'b1, 1, got);
    check(got[0], 8'h00);
    i_host.read_seq(ADDR_HT, 1'b1, 1, got);
    check(got[0], 8'h40);
    check({7'h0, rst_pin_oe_n}, 8'h01);
    repeat (TICKW) @(negedge mclk);
    i_host.read_seq(ADDR_SUBSEC, 1'b1, 8, got);
    cmpn(got, TV, 8);
    i_host.write_seq(ADDR_HT, '{default: 8'h00}, 1);
    i_host.read_seq(ADDR_SUBSEC, 1'b1, 1, got);
    check({7'h0, got[0] !== TV[0]}, 8'h01);
    end_of_test();
  end
endmodule
